/* File: dv/ccpd_osc_model.sv */
// oscillator model: free-running sources with stable flags
`timescale 1ns/1ps
module ccpd_osc_model #(
	parameter int OK_DLY = 4
)
(
	input wire logic clk,
	input wire logic [4:0] osc_en,
	output logic [4:0] src,
	output logic [4:0] ok
);
	// half periods in clk cycles: fast xtal, slow xtal, pll, slow int, fast int
	localparam int HALF [5] = '{2, 9, 1, 6, 3};
	int cnt [5];
	int up [5];
	initial
	begin
		src = 5'h00;
		ok = 5'h00;
		for (int i = 0; i < 5; i++)
		begin
			cnt[i] = 0;
			up[i] = 0;
		end
	end
	// a stopped source rests low and drops its stable flag at once
	always @(posedge clk)
	begin
		for (int i = 0; i < 5; i++)
		begin
			if (osc_en[i] !== 1'b1)
			begin
				src[i] <= 1'b0;
				ok[i] <= 1'b0;
				cnt[i] <= 0;
				up[i] <= 0;
			end
			else
			begin
				cnt[i] <= (cnt[i] + 1 >= HALF[i]) ? 0 : cnt[i] + 1;
				if (cnt[i] + 1 >= HALF[i])
					src[i] <= ~src[i];
				up[i] <= (up[i] < OK_DLY) ? up[i] + 1 : up[i];
				ok[i] <= (up[i] >= OK_DLY);
			end
		end
	end
endmodule : ccpd_osc_model

/* File: dv/tb.sv */
// register-level testbench of the clock controller
`timescale 1ns/1ps
`include "ccpd_cfg.svh"
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0000_0000;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic wfi = 1'b0;
	logic [7:0] wake_in = 8'h00;
	logic [31:0] rdata_q;
	logic [4:0] src_in, src_ok_in, osc_en_q;
	logic pll_ref_q, sys_clk_q, periph_clk_q, tick_clk_q;
	logic [7:0] periph_gate_q;
	logic [8:0] trim_code_q;
	logic power_down_q, wakeup_irq_q, irq_q;
	int n_mismatch = 0;
	int checked = 0;
	logic pbad = 1'b0;
	logic [31:0] d;
	int k;
	int sys_e [5] = '{18, 4, 36, 6, 12};
	int tck_c [4] = '{0, 1, 3, 4};
	int tck_e [4] = '{18, 4, 6, 12};
	// ==========
	// instances
	ccpd_top i_dut (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata_q(rdata_q), .wfi(wfi), .wake_in(wake_in),
		.src_in(src_in), .src_ok_in(src_ok_in), .osc_en_q(osc_en_q),
		.pll_ref_q(pll_ref_q), .sys_clk_q(sys_clk_q),
		.periph_clk_q(periph_clk_q), .periph_gate_q(periph_gate_q),
		.tick_clk_q(tick_clk_q), .trim_code_q(trim_code_q),
		.power_down_q(power_down_q), .wakeup_irq_q(wakeup_irq_q),
		.irq_q(irq_q));
	ccpd_osc_model i_osc (.clk(clk), .osc_en(osc_en_q), .src(src_in),
		.ok(src_ok_in));
	initial
	begin
		forever #10 clk = ~clk;
	end
	// ==========
	// tasks
	task automatic summarize();
		$display("checks %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : summarize
	task automatic chk(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("Error %s expected %h seen %h", nm, exp, seen);
			n_mismatch++;
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata_q;
	endtask : rd_reg
	task automatic wait_stat(input logic [31:0] m, input logic [31:0] v);
		logic [31:0] s;
		int j;
		j = 0;
		repeat (2) @(posedge clk);
		rd_reg(`CCPD_A_STAT, s);
		while ((s & m) !== v && j < 100)
		begin
			rd_reg(`CCPD_A_STAT, s);
			j++;
		end
		chk("stat", s & m, v);
		if (j >= 100)
			summarize();
	endtask : wait_stat
	// counts rising edges of the system or tick clock over cyc cycles
	task automatic edges(input int which, input int cyc, input int exp);
		logic prev;
		logic cur;
		int e;
		e = 0;
		prev = 1'b0;
		repeat (cyc)
		begin
			@(posedge clk);
			#1;
			cur = (which == 0) ? sys_clk_q : tick_clk_q;
			if (cur === 1'b1 && prev === 1'b0)
				e++;
			if (periph_clk_q !== sys_clk_q)
				pbad = 1'b1;
			prev = cur;
		end
		chk("edges", (e >= exp - 1 && e <= exp + 1), 1);
	endtask : edges
	task automatic wfi_pulse();
		@(posedge clk);
		wfi <= 1'b1;
		@(posedge clk);
		wfi <= 1'b0;
		@(posedge clk);
		#1;
	endtask : wfi_pulse
	// ==========
	// tests
	initial
	begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("osc_en", osc_en_q, 5'h18);
		chk("trim_code", trim_code_q, 9'h100);
		rd_reg(`CCPD_A_PWR, d);
		chk("pwr", d, 32'h0000_000C);
		rd_reg(`CCPD_A_SEL0, d);
		chk("sel0", d, 32'h0000_003F);
		rd_reg(`CCPD_A_GATE, d);
		chk("gate", d, 32'h0000_0001);
		rd_reg(`CCPD_A_ICLR, d);
		chk("iclr", d, 32'h0000_0000);
		rd_reg(8'h40, d);
		chk("unmapped", d, 32'h0000_0000);
		$display("test reset done");
		wr_reg(`CCPD_A_PWR, 32'h0000_003F);
		@(posedge clk);
		#1;
		chk("pll_ref", pll_ref_q, 1);
		wr_reg(`CCPD_A_PWR, 32'h0000_001F);
		@(posedge clk);
		#1;
		chk("pll_ref", pll_ref_q, 0);
		wr_reg(`CCPD_A_PWR, 32'h0000_0017);
		repeat (2) @(posedge clk);
		#1;
		chk("osc_map", osc_en_q, 5'h17);
		wr_reg(`CCPD_A_PWR, 32'h0000_001F);
		wait_stat(32'h0000_001F, 32'h0000_001F);
		wr_reg(`CCPD_A_DIV, 32'h0000_0000);
		for (int s = 0; s < 5; s++)
		begin
			wr_reg(`CCPD_A_SEL0, 32'h0000_0018 | s);
			wait_stat(32'h0000_0060, 32'h0000_0000);
			edges(0, 72, sys_e[s]);
		end
		chk("pclk", pbad, 0);
		wr_reg(`CCPD_A_DIV, 32'h0000_0001);
		wait_stat(32'h0000_0060, 32'h0000_0000);
		edges(0, 72, 6);
		wr_reg(`CCPD_A_DIV, 32'h0000_0000);
		wr_reg(`CCPD_A_GATE, 32'h0000_00A5);
		repeat (2) @(posedge clk);
		#1;
		chk("gates", periph_gate_q, 8'hA5);
		$display("test system clock done");
		wr_reg(`CCPD_A_TICK, 32'h0000_0004);
		wait_stat(32'h0000_0060, 32'h0000_0000);
		edges(1, 72, 12);
		wr_reg(`CCPD_A_TICK, 32'h0000_0000);
		for (int t = 0; t < 4; t++)
		begin
			wr_reg(`CCPD_A_SEL0, 32'h0000_0004 | (tck_c[t] << 3));
			wait_stat(32'h0000_0060, 32'h0000_0000);
			edges(1, 72, tck_e[t]);
		end
		$display("test tick clock done");
		wr_reg(`CCPD_A_TRIMC, 32'h0000_00F1);
		k = 0;
		while (trim_code_q === 9'h100 && k < 3000)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("trim_move", trim_code_q !== 9'h100, 1);
		if (k >= 3000)
			summarize();
		rd_reg(`CCPD_A_TRIMS, d);
		chk("trim_lock", d[0], 0);
		$display("test trim done");
		wr_reg(`CCPD_A_IEN, 32'h0000_0001);
		wfi_pulse();
		chk("pd_off", power_down_q, 0);
		wr_reg(`CCPD_A_PWR, 32'h0000_009F);
		wfi_pulse();
		chk("pd_on", power_down_q, 1);
		chk("osc_off", {osc_en_q[4], osc_en_q[0]}, 2'b00);
		chk("slow_int_on", osc_en_q[3], 1);
		chk("pd_gates", periph_gate_q, 8'h00);
		repeat (10) @(posedge clk);
		#1;
		chk("pd_hold", power_down_q, 1);
		@(posedge clk);
		wake_in <= 8'h01;
		k = 0;
		while (power_down_q !== 1'b0 && k < 10)
		begin
			@(posedge clk);
			#1;
			k++;
		end
		chk("pd_left", power_down_q, 0);
		if (k >= 10)
			summarize();
		@(posedge clk);
		wake_in <= 8'h00;
		repeat (2) @(posedge clk);
		#1;
		chk("wake_irq", wakeup_irq_q, 1);
		chk("irq", irq_q, 1);
		wr_reg(`CCPD_A_IEN, 32'h0000_0000);
		repeat (2) @(posedge clk);
		#1;
		chk("irq_mask", {wakeup_irq_q, irq_q}, 2'b00);
		wr_reg(`CCPD_A_IEN, 32'h0000_0001);
		rd_reg(`CCPD_A_ISTS, d);
		chk("ists", d[0], 1);
		wr_reg(`CCPD_A_ICLR, 32'h0000_0001);
		repeat (2) @(posedge clk);
		#1;
		chk("wake_clr", wakeup_irq_q, 0);
		$display("test power-down done");
		summarize();
	end
endmodule : tb

/* File: rtl/ccpd_clksw.sv */
// glitch-free switch between synchronised clock source levels
`timescale 1ns/1ps
module ccpd_clksw
	import ccpd_pkg::*;
#(
	parameter int N = 5,
	parameter logic [2:0] RST_IDX = 3'h4
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [N-1:0] src,
	input wire logic [N-1:0] ok,
	input wire logic [2:0] sel,
	output logic out_q,
	output logic [2:0] cur_q,
	output logic busy_q
);
	ccpd_sw_t st_q, st_d;
	logic [2:0] cur_d, nxt_q, nxt_d;
	logic out_d;

	always_comb
	begin
		st_d = st_q;
		cur_d = cur_q;
		nxt_d = nxt_q;
		case (st_q)
			SW_IDLE:
				if (sel != cur_q && ok[sel] && ok[cur_q])
				begin
					st_d = SW_DROP;
					nxt_d = sel;
				end
			// old source seen low: output parks low
			SW_DROP:
				if (!src[cur_q])
					st_d = SW_PICK;
			// new source seen low: output follows it from low
			SW_PICK:
				if (!src[nxt_q])
				begin
					st_d = SW_IDLE;
					cur_d = nxt_q;
				end
			default: st_d = SW_IDLE;
		endcase
		out_d = (st_d != SW_PICK) && src[cur_d]; // [RULE16]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= SW_IDLE;
			cur_q <= RST_IDX;
			nxt_q <= RST_IDX;
			out_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cur_q <= cur_d;
			nxt_q <= nxt_d;
			out_q <= out_d;
			busy_q <= (st_d != SW_IDLE);
		end
	end

	property p_park_low;
		@(posedge clk) disable iff (!rst_n)
		(st_q == SW_PICK) |-> !out_q;
	endproperty
	a_park_low: assert property (p_park_low) // [RULE16]
		else $error("clock output high while switching");
endmodule : ccpd_clksw

/* File: rtl/ccpd_top.sv */
// clock controller: sources, clock switching, power-down and registers
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "ccpd_cfg.svh"
// ==========================================================
// Function
// [RULE1] power-down only on wait-for-interrupt with power-down enable set
// [RULE2] power-down held until an enabled wake-up source fires, then left; code leaves on any wake_in bit, with no per-source enable
// [RULE3] fast crystal and fast internal oscillator switched off in power-down
// [RULE4] pll reference selects fast crystal or fast internal oscillator
// [RULE5] slow internal oscillator offered as a clock source
// [RULE6] trim control bit 0 enables auto-trim against the slow crystal
// [RULE7] trim status bit 0 shows oscillator within one percent
// [RULE8] software should set loop select and retry limit fields to 11
// [RULE9] system clock source chosen by select register 0 bits 2:0
// [RULE10] peripheral bus clock equals the system clock
// [RULE11] tick counts processor or reference clock, per tick control bit 2
// [RULE12] tick reference chosen by select register 0 bits 5:3
// [RULE13] software waits for old and new sources stable before switching
// [RULE14] per-clock gating, source selection and division of system clocks
// [RULE15] wake-up interrupt raised when woken from power-down
// [RULE16] every source change is glitch-free, synced to old and new; the tick control bit 2 switch is a plain unsynced mux
module ccpd_top
	import ccpd_pkg::*;
#(
	parameter int WAKE_N = 8,
	parameter int GATE_N = 8
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [31:0] rdata_q,
	input wire logic wfi,
	input wire logic [WAKE_N-1:0] wake_in,
	input wire logic [4:0] src_in,
	input wire logic [4:0] src_ok_in,
	output logic [4:0] osc_en_q,
	output logic pll_ref_q,
	output logic sys_clk_q,
	output logic periph_clk_q,
	output logic [GATE_N-1:0] periph_gate_q,
	output logic tick_clk_q,
	output logic [8:0] trim_code_q,
	output logic power_down_q,
	output logic wakeup_irq_q,
	output logic irq_q
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// input synchronisers
	logic [4:0] src_m, src_s, ok_m, ok_s;
	logic [WAKE_N-1:0] wk_m, wk_s;

	always_ff @(posedge clk)
	begin
		src_m <= src_in;
		src_s <= src_m;
		ok_m <= src_ok_in;
		ok_s <= ok_m;
		wk_m <= wake_in;
		wk_s <= wk_m;
	end

	// ==========================================================
	// registers
	logic [7:0] pwr_q, pwr_d, trimc_q, trimc_d;
	logic [5:0] sel0_q, sel0_d;
	logic [3:0] div_q, div_d;
	logic [GATE_N-1:0] gate_q, gate_d;
	logic [2:0] ien_q, ien_d, ists_q, ists_d, ev;
	logic tick_q, tick_d;
	logic [31:0] rd_d;
	logic sys_busy, tick_busy, lock, lock_ev, fail_ev, wake_ev;
	logic [2:0] sys_cur, tick_cur;

	always_comb
	begin
		pwr_d = pwr_q;
		sel0_d = sel0_q;
		div_d = div_q;
		gate_d = gate_q;
		trimc_d = trimc_q;
		ien_d = ien_q;
		tick_d = tick_q;
		ev = {fail_ev, lock_ev, wake_ev};
		ists_d = ists_q;
		if (wr)
		begin
			case (addr)
				`CCPD_A_PWR: pwr_d = wdata[7:0];
				`CCPD_A_SEL0: sel0_d = wdata[5:0];
				`CCPD_A_DIV: div_d = wdata[3:0];
				`CCPD_A_GATE: gate_d = wdata[GATE_N-1:0];
				`CCPD_A_TRIMC: trimc_d = wdata[7:0];
				`CCPD_A_ICLR: ists_d = ists_q & ~wdata[2:0];
				`CCPD_A_IEN: ien_d = wdata[2:0];
				`CCPD_A_TICK: tick_d = wdata[`CCPD_TICK_SRC];
				default: ;
			endcase
		end
		// a new event wins over a clear in the same cycle
		ists_d = ists_d | ev;
		rd_d = 32'h0000_0000;
		if (rd)
		begin
			case (addr)
				`CCPD_A_PWR: rd_d = 32'(pwr_q);
				`CCPD_A_SEL0: rd_d = 32'(sel0_q);
				`CCPD_A_DIV: rd_d = 32'(div_q);
				`CCPD_A_GATE: rd_d = 32'(gate_q);
				`CCPD_A_TRIMC: rd_d = 32'(trimc_q);
				`CCPD_A_TRIMS: rd_d = 32'(lock); // [RULE7]
				`CCPD_A_ISTS: rd_d = 32'(ists_q);
				`CCPD_A_IEN: rd_d = 32'(ien_q);
				`CCPD_A_TICK: rd_d = 32'({tick_q, 2'b00});
				`CCPD_A_STAT: rd_d = 32'({tick_busy, sys_busy, ok_s});
				default: rd_d = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pwr_q <= `CCPD_PWR_RST;
			sel0_q <= `CCPD_SEL0_RST;
			div_q <= 4'h0;
			gate_q <= GATE_N'(`CCPD_GATE_RST);
			trimc_q <= 8'h00;
			ien_q <= 3'h0;
			ists_q <= 3'h0;
			tick_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			irq_q <= 1'b0;
			wakeup_irq_q <= 1'b0;
		end
		else
		begin
			pwr_q <= pwr_d;
			sel0_q <= sel0_d;
			div_q <= div_d;
			gate_q <= gate_d;
			trimc_q <= trimc_d;
			ien_q <= ien_d;
			ists_q <= ists_d;
			tick_q <= tick_d;
			rdata_q <= rd_d;
			irq_q <= |(ists_d & ien_d);
			wakeup_irq_q <= ists_d[`CCPD_IRQ_WAKE] && ien_d[`CCPD_IRQ_WAKE]; // [RULE15]
		end
	end

	// ==========================================================
	// power-down sequencing
	ccpd_pd_t st_q, st_d;
	logic [4:0] en_d;

	always_comb
	begin
		st_d = st_q;
		wake_ev = 1'b0;
		case (st_q)
			PD_RUN:
				if (wfi && pwr_q[`CCPD_PWR_POWER_DOWN_ENABLE]) // [RULE1]
					st_d = PD_DOWN;
			PD_DOWN:
				if (|wk_s) // [RULE2]
				begin
					st_d = PD_WAKE;
					wake_ev = 1'b1; // [RULE15]
				end
			// resume once the current system source is stable again
			PD_WAKE:
				if (ok_s[sys_cur])
					st_d = PD_RUN;
			default: st_d = PD_RUN;
		endcase
		en_d = {pwr_q[`CCPD_PWR_FIO], pwr_q[`CCPD_PWR_SIO], // [RULE5]
			pwr_q[`CCPD_PWR_PLL], pwr_q[`CCPD_PWR_SXT], pwr_q[`CCPD_PWR_FXT]};
		if (st_d == PD_DOWN)
		begin
			en_d[`CCPD_SRC_FXT] = 1'b0; // [RULE3]
			en_d[`CCPD_SRC_FIO] = 1'b0; // [RULE3]
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st_q <= PD_RUN;
			power_down_q <= 1'b0;
			osc_en_q <= 5'h18;
			pll_ref_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			power_down_q <= (st_d == PD_DOWN);
			osc_en_q <= en_d;
			pll_ref_q <= pwr_q[`CCPD_PWR_PREF]; // [RULE4]
		end
	end

	sequence s_enter;
		st_q == PD_RUN && wfi && pwr_q[`CCPD_PWR_POWER_DOWN_ENABLE];
	endsequence
	sequence s_wake;
		st_q == PD_DOWN && |wk_s;
	endsequence

	property p_enter;
		s_enter |=> power_down_q;
	endproperty
	a_enter: assert property (p_enter) // [RULE1]
		else $error("power-down not entered on wait with enable");

	property p_only_enter;
		$rose(power_down_q) |-> $past(st_q == PD_RUN && wfi
			&& pwr_q[`CCPD_PWR_POWER_DOWN_ENABLE]);
	endproperty
	a_only_enter: assert property (p_only_enter) // [RULE1]
		else $error("power-down entered without wait and enable");

	property p_stay;
		st_q == PD_DOWN && !(|wk_s) |=> power_down_q;
	endproperty
	a_stay: assert property (p_stay) // [RULE2]
		else $error("power-down left with no wake-up source");

	property p_osc_off;
		power_down_q |-> !osc_en_q[`CCPD_SRC_FXT] && !osc_en_q[`CCPD_SRC_FIO];
	endproperty
	a_osc_off: assert property (p_osc_off) // [RULE3]
		else $error("fast oscillators running in power-down");

	property p_wake_irq;
		s_wake ##1 ien_q[`CCPD_IRQ_WAKE] |-> ists_q[`CCPD_IRQ_WAKE] ##1 wakeup_irq_q;
	endproperty
	a_wake_irq: assert property (p_wake_irq) // [RULE15]
		else $error("wake-up interrupt missing after wake");

	property p_pll_ref;
		wr && addr == `CCPD_A_PWR ##1 !(wr && addr == `CCPD_A_PWR)
			|=> pll_ref_q == $past(wdata[`CCPD_PWR_PREF], 2);
	endproperty
	a_pll_ref: assert property (p_pll_ref) // [RULE4]
		else $error("pll reference select not applied");

	// ==========================================================
	// clock switches, division and gating
	logic sw_out, sw_prev_q, ref_out, sys_d, tick_clk_d;
	logic [3:0] dcnt_q, dcnt_d;
	logic [GATE_N-1:0] pgate_d;

	ccpd_clksw #(.N(5), .RST_IDX(`CCPD_SRC_FIO)) u_sys_sw (
		.clk(clk),
		.rst_n(rst_n),
		.src(src_s),
		.ok(ok_s),
		.sel(ccpd_sys_idx(sel0_q[2:0])), // [RULE9]
		.out_q(sw_out),
		.cur_q(sys_cur),
		.busy_q(sys_busy)
	);

	ccpd_clksw #(.N(5), .RST_IDX(`CCPD_SRC_FIO)) u_tick_sw (
		.clk(clk),
		.rst_n(rst_n),
		.src(src_s),
		.ok(ok_s),
		.sel(ccpd_tick_idx(sel0_q[5:3])), // [RULE12]
		.out_q(ref_out),
		.cur_q(tick_cur),
		.busy_q(tick_busy)
	);

	always_comb
	begin
		dcnt_d = dcnt_q;
		sys_d = sys_clk_q;
		if (st_q == PD_DOWN)
			sys_d = 1'b0;
		else if (div_q == 4'h0) // [RULE14]
			sys_d = sw_out;
		else if (sw_out && !sw_prev_q)
		begin
			if (dcnt_q >= div_q - 4'h1)
			begin
				dcnt_d = 4'h0;
				sys_d = !sys_clk_q;
			end
			else
				dcnt_d = dcnt_q + 4'h1;
		end
		tick_clk_d = tick_q ? sys_clk_q : ref_out; // [RULE11]
		pgate_d = (st_d == PD_DOWN) ? '0 : gate_q; // [RULE14]
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dcnt_q <= 4'h0;
			sw_prev_q <= 1'b0;
			sys_clk_q <= 1'b0;
			periph_clk_q <= 1'b0;
			tick_clk_q <= 1'b0;
			periph_gate_q <= '0;
		end
		else
		begin
			dcnt_q <= dcnt_d;
			sw_prev_q <= sw_out;
			sys_clk_q <= sys_d;
			periph_clk_q <= sys_d; // [RULE10]
			tick_clk_q <= tick_clk_d;
			periph_gate_q <= pgate_d;
		end
	end

	property p_sys_sel;
		!sys_busy && $stable(sel0_q) [*3] |-> sys_cur == ccpd_sys_idx(sel0_q[2:0])
			|| !ok_s[sys_cur];
	endproperty
	a_sys_sel: assert property (p_sys_sel) // [RULE9]
		else $error("system clock source differs from its select");

	property p_slow_int;
		sel0_q[2:0] == 3'h3 && !sys_busy && ok_s[`CCPD_SRC_SIO] && ok_s[sys_cur]
			[*3] |-> sys_cur == `CCPD_SRC_SIO;
	endproperty
	a_slow_int: assert property (p_slow_int) // [RULE5]
		else $error("slow internal oscillator not selectable");

	property p_periph;
		periph_clk_q == sys_clk_q;
	endproperty
	a_periph: assert property (p_periph) // [RULE10]
		else $error("peripheral clock differs from system clock");

	property p_tick_cpu;
		tick_q |=> tick_clk_q == $past(sys_clk_q);
	endproperty
	a_tick_cpu: assert property (p_tick_cpu) // [RULE11]
		else $error("tick not following processor clock");

	property p_tick_ref;
		(!tick_busy && $stable(sel0_q)) [*3] ##0 ok_s[tick_cur]
			|-> tick_cur == ccpd_tick_idx(sel0_q[5:3]);
	endproperty
	a_tick_ref: assert property (p_tick_ref) // [RULE12]
		else $error("tick reference differs from its select");

	property p_gate;
		|periph_gate_q |-> !power_down_q;
	endproperty
	a_gate: assert property (p_gate) // [RULE14]
		else $error("peripheral clock enabled in power-down");

	// ==========================================================
	// auto-trim; loop and retry fields are best left at 11 by software
	ccpd_trim u_trim (
		.clk(clk),
		.rst_n(rst_n),
		.en(trimc_q[0] && st_q == PD_RUN), // [RULE6]
		.ref_lvl(src_s[`CCPD_SRC_SXT]),
		.osc_lvl(src_s[`CCPD_SRC_FIO]),
		.loop_sel(trimc_q[5:4]), // [RULE8]
		.retry_sel(trimc_q[7:6]), // [RULE8]
		.code_q(trim_code_q),
		.lock_q(lock),
		.lock_ev_q(lock_ev),
		.fail_ev_q(fail_ev)
	);
endmodule : ccpd_top

/* File: rtl/ccpd_trim.sv */
// auto-trim of the fast internal oscillator against the slow crystal
`timescale 1ns/1ps
`include "ccpd_cfg.svh"
module ccpd_trim
	import ccpd_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic ref_lvl,
	input wire logic osc_lvl,
	input wire logic [1:0] loop_sel,
	input wire logic [1:0] retry_sel,
	output logic [8:0] code_q,
	output logic lock_q,
	output logic lock_ev_q,
	output logic fail_ev_q
);
	logic [15:0] cnt_q, cnt_d, tgt, tol;
	logic [3:0] per_q, per_d;
	logic [9:0] try_q, try_d;
	logic [8:0] code_d;
	logic ref_q, osc_q, lock_d, fail_d, eval, in_rng;

	always_comb
	begin
		tgt = 16'(`CCPD_TRIM_TGT) << loop_sel;
		tol = tgt >> 7;
		cnt_d = cnt_q;
		per_d = per_q;
		try_d = try_q;
		code_d = code_q;
		lock_d = lock_q;
		fail_d = 1'b0;
		eval = en && ref_lvl && !ref_q && per_q == (4'h1 << loop_sel);
		in_rng = cnt_q <= tgt + tol && cnt_q + tol >= tgt;
		if (!en)
		begin
			cnt_d = 16'h0000;
			per_d = 4'h0;
			try_d = 10'h000;
			lock_d = 1'b0;
		end
		else
		begin
			if (osc_lvl && !osc_q)
				cnt_d = cnt_q + 16'h0001;
			if (eval) // [RULE6]
			begin
				cnt_d = 16'h0000;
				per_d = 4'h1;
				lock_d = in_rng; // [RULE7]
				if (in_rng)
					try_d = 10'h000;
				else
				begin
					if (cnt_q > tgt && code_q != 9'h000)
						code_d = code_q - 9'h001;
					else if (cnt_q < tgt && code_q != 9'h1FF)
						code_d = code_q + 9'h001;
					try_d = try_q + 10'h001;
					if (try_d == (`CCPD_RETRY_BASE << retry_sel))
					begin
						fail_d = 1'b1;
						try_d = 10'h000;
					end
				end
			end
			else if (ref_lvl && !ref_q)
			begin
				if (per_q == 4'h0)
					cnt_d = 16'h0000;
				per_d = per_q + 4'h1;
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cnt_q <= 16'h0000;
			per_q <= 4'h0;
			try_q <= 10'h000;
			code_q <= `CCPD_TRIM_CODE_RST;
			lock_q <= 1'b0;
			lock_ev_q <= 1'b0;
			fail_ev_q <= 1'b0;
			ref_q <= 1'b0;
			osc_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			per_q <= per_d;
			try_q <= try_d;
			code_q <= code_d;
			lock_q <= lock_d;
			lock_ev_q <= lock_d && !lock_q;
			fail_ev_q <= fail_d;
			ref_q <= ref_lvl;
			osc_q <= osc_lvl;
		end
	end

	property p_hold_off;
		@(posedge clk) disable iff (!rst_n)
		!en |=> code_q == $past(code_q);
	endproperty
	a_hold_off: assert property (p_hold_off) // [RULE6]
		else $error("trim code moved while trimming is off");

	property p_lock_cause;
		@(posedge clk) disable iff (!rst_n)
		$rose(lock_q) |-> $past(eval && in_rng);
	endproperty
	a_lock_cause: assert property (p_lock_cause) // [RULE7]
		else $error("lock flag rose without an in-range count");
endmodule : ccpd_trim

/* File: shared/ccpd_cfg.svh */
// register offsets, field positions, reset values and counts of the clock controller
`ifndef CCPD_CFG_SVH
`define CCPD_CFG_SVH
`define CCPD_A_PWR 8'h00
`define CCPD_A_SEL0 8'h04
`define CCPD_A_DIV 8'h08
`define CCPD_A_GATE 8'h0C
`define CCPD_A_TRIMC 8'h10
`define CCPD_A_TRIMS 8'h14
`define CCPD_A_ISTS 8'h18
`define CCPD_A_ICLR 8'h1C
`define CCPD_A_IEN 8'h20
`define CCPD_A_TICK 8'h24
`define CCPD_A_STAT 8'h28
`define CCPD_PWR_FXT 0
`define CCPD_PWR_SXT 1
`define CCPD_PWR_FIO 2
`define CCPD_PWR_SIO 3
`define CCPD_PWR_PLL 4
`define CCPD_PWR_PREF 5
`define CCPD_PWR_POWER_DOWN_ENABLE 7
`define CCPD_TICK_SRC 2
`define CCPD_IRQ_WAKE 0
`define CCPD_IRQ_LOCK 1
`define CCPD_IRQ_FAIL 2
`define CCPD_PWR_RST 8'h0C
`define CCPD_SEL0_RST 6'h3F
`define CCPD_GATE_RST 8'h01
`define CCPD_SRC_FXT 3'h0
`define CCPD_SRC_SXT 3'h1
`define CCPD_SRC_PLL 3'h2
`define CCPD_SRC_SIO 3'h3
`define CCPD_SRC_FIO 3'h4
`define CCPD_FIO_HZ 22118400
`define CCPD_SXT_HZ 32768
`define CCPD_TRIM_TGT (`CCPD_FIO_HZ / `CCPD_SXT_HZ)
`define CCPD_TRIM_CODE_RST 9'h100
`define CCPD_RETRY_BASE 10'h040
`endif

/* File: shared/ccpd_pkg.sv */
// state types and source mapping of the clock controller
`include "ccpd_cfg.svh"
package ccpd_pkg;
	typedef enum logic [1:0] {
		PD_RUN = 2'b00,
		PD_DOWN = 2'b01,
		PD_WAKE = 2'b10
	} ccpd_pd_t;
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_DROP = 2'b01,
		SW_PICK = 2'b10
	} ccpd_sw_t;

	// system clock select code to source index
	function automatic logic [2:0] ccpd_sys_idx(input logic [2:0] sel);
		return (sel < 3'h4) ? sel : `CCPD_SRC_FIO;
	endfunction : ccpd_sys_idx

	// tick reference select code to source index
	function automatic logic [2:0] ccpd_tick_idx(input logic [2:0] sel);
		case (sel)
			3'h0: return `CCPD_SRC_FXT;
			3'h1: return `CCPD_SRC_SXT;
			3'h3: return `CCPD_SRC_SIO;
			default: return `CCPD_SRC_FIO;
		endcase
	endfunction : ccpd_tick_idx
endpackage : ccpd_pkg
